// ===== hdl/bfie_boost_fault_irq.sv
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module bfie_boost_fault_irq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic thermal_shutdown_fault,
  input wire logic current_set_resistor_short_fault,
  input wire logic string_count_resistor_missing_fault,
  input wire logic mode_resistor_missing_fault,
  input wire logic frequency_resistor_missing_fault,
  input wire logic boost_overcurrent_fault,
  input wire logic boost_overvoltage_high_fault,
  output logic irq
);

  // One enable bit per fault; index 0 is over-voltage-high, 6 is thermal
  logic [6:0] enable_r;
  logic [6:0] enable_nxt;
  logic [6:0] status_r;
  logic [6:0] status_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [6:0] faults;
  logic access;
  logic hit_enable;
  logic hit_status;
  logic hit_clear;

  // Applies a write command to one enable bit; codes 0 and 2 hold it
  function automatic logic bfie_apply(input logic cur, input logic [1:0] code);
    logic res;
    res = cur;
    if (code == bfie_pkg::BFIE_CMD_ENABLE) begin
      res = 1'b1;
    end else if (code == bfie_pkg::BFIE_CMD_DISABLE) begin
      res = 1'b0;
    end
    return res;
  endfunction

  // Packs enable bits into the readback layout
  function automatic logic [15:0] bfie_pack_enables(input logic [6:0] en);
    logic [15:0] word;
    word = 16'h0000; // Reserved bits 1:0 stay zero
    for (int i = 0; i < bfie_pkg::BFIE_NUM_FAULTS; i++) begin
      word[2*i+bfie_pkg::BFIE_FIELD_BASE +: 2] = en[i] ? bfie_pkg::BFIE_READ_ENABLED
                                                       : bfie_pkg::BFIE_READ_DISABLED;
    end
    return word;
  endfunction

  // Packs status bits onto the high bit of each field
  function automatic logic [15:0] bfie_pack_status(input logic [6:0] st);
    logic [15:0] word;
    word = 16'h0000;
    for (int i = 0; i < bfie_pkg::BFIE_NUM_FAULTS; i++) begin
      word[2*i+bfie_pkg::BFIE_FIELD_BASE+1] = st[i];
    end
    return word;
  endfunction

  // Fault vector, thermal in the top bit and over-voltage-high in bit 0
  assign faults = {thermal_shutdown_fault, current_set_resistor_short_fault,
                   string_count_resistor_missing_fault, mode_resistor_missing_fault,
                   frequency_resistor_missing_fault, boost_overcurrent_fault,
                   boost_overvoltage_high_fault};

  // Address decode and the completing edge of an access phase
  assign access = psel && penable && pready_r;
  assign hit_enable = (paddr == bfie_pkg::BFIE_ENABLE_ADDR);
  assign hit_status = (paddr == bfie_pkg::BFIE_STATUS_ADDR);
  assign hit_clear = (paddr == bfie_pkg::BFIE_CLEAR_ADDR);

  // Bus answer: one wait state, so data is registered and outputs come from flops
  always_comb begin
    pready_nxt = psel && penable && !pready_r;
    prdata_nxt = bfie_pkg::BFIE_RDATA_RESET;
    pslverr_nxt = 1'b0;
    if (pready_nxt) begin
      if (hit_enable) begin
        prdata_nxt = {16'h0000, bfie_pack_enables(enable_r)};
      end else if (hit_status) begin
        prdata_nxt = {16'h0000, bfie_pack_status(status_r)};
      end else if (hit_clear) begin
        prdata_nxt = bfie_pkg::BFIE_RDATA_RESET; // Clear register reads as zero
      end else begin
        pslverr_nxt = 1'b1; // Unmapped address
      end
      if (pwrite) begin
        prdata_nxt = bfie_pkg::BFIE_RDATA_RESET;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= bfie_pkg::BFIE_RDATA_RESET;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Enable commands and sticky status; a byte lane must be strobed to act
  always_comb begin
    enable_nxt = enable_r;
    status_nxt = status_r;
    for (int i = 0; i < bfie_pkg::BFIE_NUM_FAULTS; i++) begin
      if (access && pwrite && hit_enable && pstrb[(2*i+bfie_pkg::BFIE_FIELD_BASE)/8]) begin
        enable_nxt[i] = bfie_apply(enable_r[i], pwdata[2*i+bfie_pkg::BFIE_FIELD_BASE +: 2]);
      end
      if (access && pwrite && hit_clear && pstrb[(2*i+bfie_pkg::BFIE_FIELD_BASE)/8]
          && pwdata[2*i+bfie_pkg::BFIE_FIELD_BASE+1]) begin
        status_nxt[i] = 1'b0;
      end
      // A fault in the clearing cycle is kept: set beats clear
      if (faults[i]) begin
        status_nxt[i] = 1'b1;
      end
    end
    irq_nxt = |(status_nxt & enable_nxt);
  end

  // Enable reset values are taken from the packed register image; status resets from BFIE_STATUS_RESET
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= {bfie_pkg::BFIE_ENABLE_RESET[bfie_pkg::BFIE_THERMAL_LSB+1],
                   bfie_pkg::BFIE_ENABLE_RESET[bfie_pkg::BFIE_ISET_SHORT_LSB+1],
                   bfie_pkg::BFIE_ENABLE_RESET[bfie_pkg::BFIE_STRING_COUNT_LSB+1],
                   bfie_pkg::BFIE_ENABLE_RESET[bfie_pkg::BFIE_MODE_RES_LSB+1],
                   bfie_pkg::BFIE_ENABLE_RESET[bfie_pkg::BFIE_FREQ_RES_LSB+1],
                   bfie_pkg::BFIE_ENABLE_RESET[bfie_pkg::BFIE_OVERCURRENT_LSB+1],
                   bfie_pkg::BFIE_ENABLE_RESET[bfie_pkg::BFIE_OVERVOLTAGE_LSB+1]};
      status_r <= bfie_pkg::BFIE_STATUS_RESET;
      irq_r <= 1'b0;
    end else begin
      enable_r <= enable_nxt;
      status_r <= status_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;

  // Checks on the block's own outputs and state
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_enable_write;
    psel && penable && pready_r && pwrite && (paddr == bfie_pkg::BFIE_ENABLE_ADDR);
  endsequence

  sequence s_enable_read_done;
    psel && penable && pready_r && !pwrite && (paddr == bfie_pkg::BFIE_ENABLE_ADDR);
  endsequence

  AST_RESET_IMAGE: assert property (
    $rose(presetn) |-> (bfie_pack_enables(enable_r) == bfie_pkg::BFIE_ENABLE_RESET))
    else $error("Enable register did not leave reset at its reset image");

  AST_READBACK_CODES: assert property (
    s_enable_read_done |-> (prdata_r == {16'h0000, bfie_pack_enables(enable_r)})
                           && (prdata_r[15:2] & 14'h1555) == 14'h0000)
    else $error("Enable readback is not made of codes 0 and 2");

  AST_FIELD_RESETS: assert property (
    $rose(presetn) |-> (enable_r == 7'h63))
    else $error("Enable fields did not reset to their documented states");

  AST_RESERVED_ZERO: assert property (
    s_enable_read_done |-> (prdata_r[bfie_pkg::BFIE_RESERVED_LSB +: 2] == 2'h0))
    else $error("Reserved enable bits read nonzero");

  AST_IRQ_GATING: assert property (
    irq_r == |(status_r & enable_r))
    else $error("Interrupt output does not follow enabled status");

  AST_PREADY_PULSE: assert property (
    psel && penable && !pready_r |=> pready_r ##1 !pready_r)
    else $error("Bus answer is not a single cycle after one wait state");

  // The answer never comes unasked: it follows an access cycle
  AST_PREADY_AFTER_ACCESS: assert property (
    pready_r |-> $past(psel) && $past(penable))
    else $error("Bus answer without a preceding access cycle");

  // Answer shape is checked against the address map, not the design's own decode
  sequence s_bus_done;
    psel && penable && pready_r;
  endsequence

  sequence s_clear_write;
    psel && penable && pready_r && pwrite && (paddr == bfie_pkg::BFIE_CLEAR_ADDR);
  endsequence

  sequence s_unmapped_done;
    s_bus_done ##0 ((paddr != bfie_pkg::BFIE_ENABLE_ADDR) && (paddr != bfie_pkg::BFIE_STATUS_ADDR)
                    && (paddr != bfie_pkg::BFIE_CLEAR_ADDR));
  endsequence

  AST_ERROR_UNMAPPED: assert property (
    s_unmapped_done |-> pslverr_r && (prdata_r == 32'h0000_0000))
    else $error("Access to an unmapped address was not refused");

  AST_ERROR_WITH_READY: assert property (
    pslverr_r |-> pready_r)
    else $error("Bus error flagged outside the answer cycle");

  AST_UPPER_HALF_ZERO: assert property (
    s_bus_done |-> (prdata_r[31:16] == 16'h0000))
    else $error("Read data above the 16-bit register is not zero");

  // Idle data is zero so that a stale word cannot be mistaken for an answer
  AST_DATA_IDLE_ZERO: assert property (
    !pready_r |-> (prdata_r == 32'h0000_0000))
    else $error("Read data is not zero outside the answer cycle");

  AST_WRITE_DATA_ZERO: assert property (
    s_bus_done ##0 pwrite |-> (prdata_r == 32'h0000_0000))
    else $error("Write answer carries nonzero data");

  AST_CLEAR_READS_ZERO: assert property (
    s_bus_done ##0 (!pwrite && (paddr == bfie_pkg::BFIE_CLEAR_ADDR)) |-> (prdata_r == 32'h0000_0000))
    else $error("Clear register did not read as zero");

  // Status words carry only the high bit of each field
  AST_STATUS_LAYOUT: assert property (
    s_bus_done ##0 (!pwrite && (paddr == bfie_pkg::BFIE_STATUS_ADDR))
    |-> ((prdata_r & 32'hFFFF_5557) == 32'h0000_0000))
    else $error("Status word has bits outside the fault positions");

  // Only a completed write to the enable register may move the enables
  AST_ENABLE_ONLY_BY_WRITE: assert property (
    !(psel && penable && pready_r && pwrite && (paddr == bfie_pkg::BFIE_ENABLE_ADDR)) |=> $stable(enable_r))
    else $error("Enable register changed without a write to it");

  for (genvar g = 0; g < 7; g++) begin : gen_field_checks
    localparam int LSB = 2*g+bfie_pkg::BFIE_FIELD_BASE;
    AST_ENABLE_CMD: assert property (
      s_enable_write ##0 (pstrb[LSB/8] && pwdata[LSB +: 2] == 2'h3) |=> enable_r[g] ##1 enable_r[g])
      else $error("Enable command did not enable the field");
    AST_DISABLE_CMD: assert property (
      s_enable_write ##0 (pstrb[LSB/8] && pwdata[LSB +: 2] == 2'h1) |=> !enable_r[g])
      else $error("Disable command did not disable the field");
    AST_HOLD_CMD: assert property (
      s_enable_write ##0 (!pwdata[LSB]) |=> (enable_r[g] == $past(enable_r[g])))
      else $error("Code 0 or 2 changed the field state");
    AST_STICKY_SET: assert property (
      faults[g] |=> status_r[g] [*2] or (status_r[g] ##1 !status_r[g]))
      else $error("Fault was not captured in status");

    // Status side: clears, the race with a fault, and the path to the interrupt
    AST_CLEAR_CMD: assert property (
      s_clear_write ##0 (pstrb[LSB/8] && pwdata[LSB+1] && !faults[g]) |=> !status_r[g])
      else $error("Clear write did not drop an idle status bit");
    AST_SET_BEATS_CLEAR: assert property (
      s_clear_write ##0 faults[g] |=> status_r[g])
      else $error("Fault in the clearing cycle was lost");
    AST_STATUS_STICKY: assert property (
      status_r[g] && !faults[g] && !(psel && penable && pready_r && pwrite
      && (paddr == bfie_pkg::BFIE_CLEAR_ADDR)) |=> status_r[g])
      else $error("Status bit dropped without a clear");
    AST_STATUS_READBACK: assert property (
      s_bus_done ##0 (!pwrite && (paddr == bfie_pkg::BFIE_STATUS_ADDR))
      |-> (prdata_r[LSB+1] == $past(status_r[g])))
      else $error("Status word does not show the captured fault");
    AST_IRQ_RAISE: assert property (
      faults[g] && enable_r[g] |=> irq_r || !enable_r[g])
      else $error("Enabled fault did not raise the interrupt");
  end

endmodule
`default_nettype wire

// ===== hdl/bfie_pkg.sv
// Shared constants of the boost fault interrupt enable block
package bfie_pkg;
  // Printed register index; byte address is four times the index
  localparam logic [9:0] BFIE_ENABLE_INDEX = 10'h00A;
  localparam logic [9:0] BFIE_STATUS_INDEX = 10'h020;
  localparam logic [9:0] BFIE_CLEAR_INDEX = 10'h021;
  localparam logic [11:0] BFIE_ENABLE_ADDR = {BFIE_ENABLE_INDEX, 2'b00};
  localparam logic [11:0] BFIE_STATUS_ADDR = {BFIE_STATUS_INDEX, 2'b00};
  localparam logic [11:0] BFIE_CLEAR_ADDR = {BFIE_CLEAR_INDEX, 2'b00};
  // Whole enable register after reset
  localparam logic [15:0] BFIE_ENABLE_RESET = 16'hA028;
  // Field positions (low bit of each two-bit field)
  localparam int BFIE_THERMAL_LSB = 14;
  localparam int BFIE_ISET_SHORT_LSB = 12;
  localparam int BFIE_STRING_COUNT_LSB = 10;
  localparam int BFIE_MODE_RES_LSB = 8;
  localparam int BFIE_FREQ_RES_LSB = 6;
  localparam int BFIE_OVERCURRENT_LSB = 4;
  localparam int BFIE_OVERVOLTAGE_LSB = 2;
  localparam int BFIE_RESERVED_LSB = 0;
  // Fault i owns bits 2*i+3..2*i+2
  localparam int BFIE_FIELD_BASE = 2;
  localparam int BFIE_NUM_FAULTS = 7;
  // Write command codes and read status codes
  localparam logic [1:0] BFIE_CMD_ENABLE = 2'h3;
  localparam logic [1:0] BFIE_CMD_DISABLE = 2'h1;
  localparam logic [1:0] BFIE_READ_ENABLED = 2'h2;
  localparam logic [1:0] BFIE_READ_DISABLED = 2'h0;
  // Values after reset of the other state
  localparam logic [6:0] BFIE_STATUS_RESET = 7'h00;
  localparam logic [31:0] BFIE_RDATA_RESET = 32'h0000_0000;
endpackage

// ===== test/bfie_boost_fault_irq_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module bfie_boost_fault_irq_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [6:0] flt;
  int n_fail, check_count;
  localparam logic [11:0] EN = bfie_pkg::BFIE_ENABLE_ADDR;
  localparam logic [11:0] ST = bfie_pkg::BFIE_STATUS_ADDR;
  localparam logic [11:0] CL = bfie_pkg::BFIE_CLEAR_ADDR;
  bfie_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  bfie_boost_fault_irq DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .thermal_shutdown_fault(flt[6]), .current_set_resistor_short_fault(flt[5]),
    .string_count_resistor_missing_fault(flt[4]), .mode_resistor_missing_fault(flt[3]),
    .frequency_resistor_missing_fault(flt[2]), .boost_overcurrent_fault(flt[1]),
    .boost_overvoltage_high_fault(flt[0]), .irq(irq));
  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, 4'hF, rd, err);
    check({31'h0, err}, 32'h0);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    host.xfer(1'b0, a, 32'h0, 4'hF, rd, err);
    check(rd, exp);
    check({31'h0, err}, {31'h0, experr});
  endtask
  task automatic test_reset();
    rdchk(EN, 32'h0000_A028, 1'b0);
    rdchk(ST, 32'h0000_0000, 1'b0);
    check({31'h0, irq}, 32'h0);
    $display("test_reset done");
  endtask
  // Command codes, hold codes, lane strobes and a refused address
  task automatic test_codes();
    wr(EN, 32'h0000_5554);
    rdchk(EN, 32'h0000_0000, 1'b0);
    wr(EN, 32'hFFFF_FFFF);
    rdchk(EN, 32'h0000_AAA8, 1'b0);
    wr(EN, 32'h0000_2A18);
    rdchk(EN, 32'h0000_AA88, 1'b0);
    host.xfer(1'b1, EN, 32'h0000_5555, 4'h1, rd, err);
    check({31'h0, err}, 32'h0);
    rdchk(EN, 32'h0000_AA00, 1'b0);
    host.xfer(1'b1, 12'h02C, 32'h0000_FFFC, 4'hF, rd, err);
    check({31'h0, err}, 32'h1);
    rdchk(12'h3FC, 32'h0000_0000, 1'b1);
    rdchk(EN, 32'h0000_AA00, 1'b0);
    $display("test_codes done");
  endtask
  // Each fault is held off while masked, then reaches irq once enabled
  task automatic test_irq();
    wr(EN, 32'h0000_5554);
    for (int i = 0; i < 7; i++) begin
      @(posedge pclk);
      flt <= 7'h01 << i;
      @(posedge pclk);
      flt <= 7'h00;
      repeat (2) @(posedge pclk);
      #1;
      check({31'h0, irq}, 32'h0);
      rdchk(ST, 32'h1 << (2 * i + 3), 1'b0);
      wr(EN, 32'h3 << (2 * i + 2));
      repeat (2) @(posedge pclk);
      #1;
      check({31'h0, irq}, 32'h1);
      rdchk(EN, 32'h2 << (2 * i + 2), 1'b0);
      wr(CL, 32'h1 << (2 * i + 3));
      wr(EN, 32'h1 << (2 * i + 2));
      repeat (2) @(posedge pclk);
      #1;
      check({31'h0, irq}, 32'h0);
    end
    $display("test_irq done");
  endtask
  // A held fault outlives a clear, status ignores writes, and a mid-run reset restores the image
  task automatic test_sticky();
    wr(EN, 32'h0000_C000);
    check({31'h0, irq}, 32'h0);
    flt <= 7'h40;
    @(posedge pclk);
    #1;
    check({31'h0, irq}, 32'h1);
    wr(CL, 32'h0000_8000);
    rdchk(ST, 32'h0000_8000, 1'b0);
    rdchk(CL, 32'h0000_0000, 1'b0);
    flt <= 7'h00;
    wr(ST, 32'h0000_FFFF);
    rdchk(ST, 32'h0000_8000, 1'b0);
    check({31'h0, irq}, 32'h1);
    wr(CL, 32'h0000_8000);
    rdchk(ST, 32'h0000_0000, 1'b0);
    check({31'h0, irq}, 32'h0);
    wr(EN, 32'hFFFF_FFFF);
    flt <= 7'h01;
    @(posedge pclk);
    flt <= 7'h00;
    @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    presetn <= 1'b1;
    rdchk(EN, 32'h0000_A028, 1'b0);
    rdchk(ST, 32'h0000_0000, 1'b0);
    $display("test_sticky done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests take
  initial begin
    #20000;
    n_fail++;
    wrap_up();
  end
  initial begin
    n_fail = 0;
    check_count = 0;
    flt = 7'h00;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_codes();
    test_irq();
    test_sticky();
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== test/bfie_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// APB master standing in for the host software
module bfie_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Bus idle from time zero, so nothing is requested during reset
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end
  // One whole transfer, held until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    // Released address and data lines show the inverse, so a stale value cannot pass for live data
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire
